// *** rtl/opgen_pkg.sv ***
// constants, types and helpers for operand address generation
// assumes one clock domain and byte-wide program and operand memory
package opgen_pkg;
  // prefix and opcode values
  localparam logic [7:0] PFX_FIRST = 8'hDD;
  localparam logic [7:0] PFX_SECOND = 8'hFD;
  localparam logic [7:0] PFX_BIT = 8'hCB;
  localparam logic [7:0] PFX_EXT = 8'hED;
  localparam logic [7:0] OP_LD_PTR_IMM = 8'h36;
  localparam logic [7:0] OP_LD_PAIR_IMM = 8'h21;
  localparam logic [7:0] OP_HALT = 8'h76;
  localparam logic [7:0] OP_COPY_EXAMPLE = 8'h48;
  localparam logic [7:0] OP_STORE_EXAMPLE = 8'h72;
  localparam logic [7:0] OP_MOVE_INC = 8'hA0;
  localparam logic [7:0] OP_MOVE_DEC = 8'hA8;
  localparam logic [7:0] OP_CMP_INC = 8'hA1;
  localparam logic [7:0] OP_CMP_DEC = 8'hA9;
  localparam logic [7:0] OP_PAIR_VIA_PTR = 8'h34;
  // opcode class in bits 7:6
  localparam logic [1:0] CLS_MISC = 2'h0;
  localparam logic [1:0] CLS_LOAD = 2'h1;
  localparam logic [1:0] CLS_ALU = 2'h2;
  localparam logic [1:0] CLS_BIT_TEST = 2'h1;
  localparam logic [1:0] CLS_BIT_SET = 2'h3;
  // register field codes
  localparam logic [2:0] REG_B = 3'h0;
  localparam logic [2:0] REG_C = 3'h1;
  localparam logic [2:0] REG_D = 3'h2;
  localparam logic [2:0] REG_E = 3'h3;
  localparam logic [2:0] REG_H = 3'h4;
  localparam logic [2:0] REG_L = 3'h5;
  localparam logic [2:0] REG_MEM = 3'h6;
  localparam logic [2:0] REG_A = 3'h7;
  // arithmetic field codes
  localparam logic [2:0] ALU_ADD = 3'h0;
  localparam logic [2:0] ALU_ADC = 3'h1;
  localparam logic [2:0] ALU_AND = 3'h4;
  localparam logic [2:0] ALU_XOR = 3'h5;
  localparam logic [2:0] ALU_OR = 3'h6;
  localparam logic [2:0] ALU_CP = 3'h7;
  // index selection, also the wide write target
  localparam logic [1:0] IDX_NONE = 2'h0;
  localparam logic [1:0] IDX_FIRST = 2'h1;
  localparam logic [1:0] IDX_SECOND = 2'h2;
  localparam logic [1:0] WIDE_DE = 2'h3;
  // reset values and steps
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WIDE = 16'h0000;
  localparam logic [15:0] PTR_STEP = 16'h0001;

  typedef enum logic [2:0] {
    ST_OPC = 3'b000, ST_DISP = 3'b001, ST_OP2 = 3'b011, ST_IMM = 3'b010,
    ST_IMM_HI = 3'b110, ST_RD = 3'b111, ST_RD_HI = 3'b101, ST_WR = 3'b100
  } seq_state_type;

  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mem_cmd_type;

  typedef struct packed {
    logic [7:0] a, b, c, d, e, h, l;
    logic [15:0] first_index, second_index;
  } core_view_type;

  // signed displacement, sum wraps in 16 bits
  function automatic logic [15:0] index_sum(input logic [15:0] base,
                                            input logic [7:0] disp);
    return base + {{8{disp[7]}}, disp};
  endfunction

  function automatic logic [15:0] step_ptr(input logic [15:0] p,
                                           input logic down);
    return down ? p - PTR_STEP : p + PTR_STEP;
  endfunction

  // carry is not kept, so carry forms act as their plain forms
  function automatic logic [7:0] alu_apply(input logic [2:0] op,
                                           input logic [7:0] a,
                                           input logic [7:0] s);
    case (op)
      ALU_ADD, ALU_ADC: return a + s;
      ALU_AND: return a & s;
      ALU_XOR: return a ^ s;
      ALU_OR: return a | s;
      default: return a - s;
    endcase
  endfunction

  function automatic logic [7:0] bit_apply(input logic [7:0] op,
                                           input logic [7:0] v);
    logic [7:0] m;
    m = 8'h01 << op[5:3];
    return (op[7:6] == CLS_BIT_SET) ? (v | m) : (v & ~m);
  endfunction

  function automatic logic uses_mem(input logic [7:0] op);
    return (op == OP_LD_PTR_IMM) || (op[7:6] == CLS_ALU && op[2:0] == REG_MEM)
      || (op[7:6] == CLS_LOAD && op != OP_HALT
          && (op[5:3] == REG_MEM || op[2:0] == REG_MEM));
  endfunction

  function automatic seq_state_type mem_route(input logic [7:0] op);
    if (op == OP_LD_PTR_IMM)
      return ST_IMM;
    else if (op[7:6] == CLS_LOAD && op[5:3] == REG_MEM)
      return ST_WR;
    else
      return ST_RD;
  endfunction
endpackage

// *** rtl/operand_address_generation.sv ***
// operand addressing and load decode of an 8-bit core
// assumes program bytes and operand memory answer on mclk
// Overview of operation
// - indexed: byte after opcode is a displacement added to an index
// - the prefix opcode chooses first or second index register as base
// - forming an indexed address never changes the index register
// - displacement is a signed two's complement byte
// - register operands come from bit fields inside the opcode
// - implied arithmetic writes its result to the accumulator, except compare (ALU_CP), which only sets the flag
// - register indirect uses a 16-bit register pair as the address
// - 16-bit indirect operand: low byte first, then pointer plus one
// - block move and search step pointers up or down and compare
// - bit set, reset, test pick one of eight bits by a 3-bit field
// - opcode 48H fetched in the fetch cycle copies B into C
// - opcode 72 stores D at the address in the primary pointer pair
// - common arithmetic is one opcode byte; others take more bytes
// - immediate source may pair with indirect or indexed destination
// - displacement byte comes right after opcode, before immediate data
// - extended immediate takes low byte first, then high byte
module operand_address_generation
  import opgen_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // instruction byte stream
  input wire logic ibyte_valid,
  input wire logic [7:0] ibyte_data,
  output logic ibyte_ready,
  output logic opcode_fetch_cycle,
  // operand memory
  output mem_cmd_type mem_cmd,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack,
  // register view
  output core_view_type core_view,
  output logic zero_flag
);
  seq_state_type state_r, st_nxt;
  logic [7:0] rf_r [0:7];
  logic [15:0] first_index_register_r, second_index_register_r;
  logic [1:0] pfx_r;
  logic ext_r, bitop_r, zero_flag_r;
  logic [7:0] op_r, imm_r, imm_nxt, wdata_r, wdata_nxt, b;
  logic [15:0] ptr_r, ptr_nxt;
  logic rf_we, wide_we, blk_step, flag_we, flag_val, insn_done;
  logic [2:0] rf_idx, alu_op;
  logic [7:0] rf_val, alu_src, alu_out, bit_op, bit_src;
  logic [1:0] wide_sel;
  logic [15:0] wide_val, primary_pointer_pair, de_pair, bc_pair, idx_base;
  logic take, is_prefix, main_take, mem_busy;

  assign b = ibyte_data;
  assign primary_pointer_pair = {rf_r[REG_H], rf_r[REG_L]};
  assign de_pair = {rf_r[REG_D], rf_r[REG_E]};
  assign bc_pair = {rf_r[REG_B], rf_r[REG_C]};
  assign idx_base = (pfx_r == IDX_FIRST) ? first_index_register_r
                                         : second_index_register_r;
  assign mem_busy = state_r inside {ST_RD, ST_RD_HI, ST_WR};
  assign ibyte_ready = !mem_busy;
  assign opcode_fetch_cycle = (state_r == ST_OPC);
  assign take = ibyte_valid && ibyte_ready;
  assign is_prefix = !ext_r && !bitop_r
    && (b inside {PFX_FIRST, PFX_SECOND, PFX_BIT, PFX_EXT});
  assign main_take = take && opcode_fetch_cycle && !is_prefix
    && !ext_r && !bitop_r;
  assign mem_cmd = '{req: mem_busy, we: (state_r == ST_WR),
                     addr: ptr_r, wdata: wdata_r};
  assign zero_flag = zero_flag_r;
  assign core_view = '{a: rf_r[REG_A], b: rf_r[REG_B], c: rf_r[REG_C],
                       d: rf_r[REG_D], e: rf_r[REG_E], h: rf_r[REG_H],
                       l: rf_r[REG_L], first_index: first_index_register_r,
                       second_index: second_index_register_r};
  // operands from the opcode in fetch, else from memory
  assign alu_op = opcode_fetch_cycle ? b[5:3] : op_r[5:3];
  assign alu_src = opcode_fetch_cycle ? rf_r[b[2:0]] : mem_rdata;
  assign alu_out = alu_apply(alu_op, rf_r[REG_A], alu_src);
  assign bit_op = opcode_fetch_cycle ? b : op_r;
  assign bit_src = opcode_fetch_cycle ? rf_r[b[2:0]] : mem_rdata;

  // decode and sequencing
  always_comb
  begin
    st_nxt = state_r;
    ptr_nxt = ptr_r;
    wdata_nxt = wdata_r;
    imm_nxt = imm_r;
    rf_we = 1'b0;
    rf_idx = op_r[5:3];
    rf_val = mem_rdata;
    wide_we = 1'b0;
    wide_sel = pfx_r;
    wide_val = {b, imm_r};
    blk_step = 1'b0;
    flag_we = 1'b0;
    flag_val = zero_flag_r;
    insn_done = 1'b0;
    case (state_r)
      ST_OPC:
        if (take && is_prefix && b == PFX_BIT && pfx_r != IDX_NONE)
          st_nxt = ST_DISP;
        else if (take && !is_prefix)
        begin
          insn_done = 1'b1;
          ptr_nxt = primary_pointer_pair;
          wdata_nxt = rf_r[b[2:0]];
          if (bitop_r && b[2:0] == REG_MEM)
          begin
            insn_done = 1'b0;
            st_nxt = ST_RD;
          end
          else if (bitop_r && b[7:6] == CLS_BIT_TEST)
          begin
            flag_we = 1'b1;
            flag_val = ~bit_src[b[5:3]];
          end
          else if (bitop_r)
          begin
            rf_we = 1'b1;
            rf_idx = b[2:0];
            rf_val = bit_apply(bit_op, bit_src);
          end
          else if (ext_r)
          begin
            if (b inside {OP_MOVE_INC, OP_MOVE_DEC, OP_CMP_INC, OP_CMP_DEC,
                          OP_PAIR_VIA_PTR})
            begin
              insn_done = 1'b0;
              st_nxt = ST_RD;
            end
          end
          else if (uses_mem(b))
          begin
            insn_done = 1'b0;
            st_nxt = (pfx_r != IDX_NONE) ? ST_DISP : mem_route(b);
          end
          else if (b == OP_LD_PAIR_IMM
                   || (b[7:6] == CLS_MISC && b[2:0] == REG_MEM))
          begin
            insn_done = 1'b0;
            st_nxt = ST_IMM;
          end
          else if (b[7:6] == CLS_LOAD && b != OP_HALT)
          begin
            rf_we = 1'b1;
            rf_idx = b[5:3];
            rf_val = rf_r[b[2:0]];
          end
          else if (b[7:6] == CLS_ALU)
          begin
            rf_we = (alu_op != ALU_CP);
            rf_idx = REG_A;
            rf_val = alu_out;
            flag_we = 1'b1;
            flag_val = (alu_out == RESET_BYTE);
          end
        end
      ST_DISP:
        if (take)
        begin
          ptr_nxt = index_sum(idx_base, b);
          st_nxt = bitop_r ? ST_OP2 : mem_route(op_r);
          wdata_nxt = rf_r[op_r[2:0]];
        end
      ST_OP2:
        if (take)
          st_nxt = ST_RD;
      ST_IMM:
        if (take)
        begin
          imm_nxt = b;
          wdata_nxt = b;
          if (op_r == OP_LD_PTR_IMM)
            st_nxt = ST_WR;
          else if (op_r == OP_LD_PAIR_IMM)
            st_nxt = ST_IMM_HI;
          else
          begin
            rf_we = 1'b1;
            rf_val = b;
            st_nxt = ST_OPC;
            insn_done = 1'b1;
          end
        end
      ST_IMM_HI:
        if (take)
        begin
          wide_we = 1'b1;
          st_nxt = ST_OPC;
          insn_done = 1'b1;
        end
      ST_RD:
        if (mem_ack)
        begin
          st_nxt = ST_OPC;
          insn_done = 1'b1;
          if (bitop_r && op_r[7:6] == CLS_BIT_TEST)
          begin
            flag_we = 1'b1;
            flag_val = ~bit_src[op_r[5:3]];
          end
          else if (bitop_r)
          begin
            wdata_nxt = bit_apply(bit_op, bit_src);
            st_nxt = ST_WR;
            insn_done = 1'b0;
          end
          else if (ext_r && op_r == OP_PAIR_VIA_PTR)
          begin
            imm_nxt = mem_rdata;
            ptr_nxt = ptr_r + PTR_STEP;
            st_nxt = ST_RD_HI;
            insn_done = 1'b0;
          end
          else if (ext_r && !op_r[0])
          begin
            wdata_nxt = mem_rdata;
            ptr_nxt = de_pair;
            st_nxt = ST_WR;
            insn_done = 1'b0;
          end
          else if (ext_r)
          begin
            flag_we = 1'b1;
            flag_val = (rf_r[REG_A] == mem_rdata);
            blk_step = 1'b1;
          end
          else if (op_r[7:6] == CLS_LOAD)
            rf_we = 1'b1;
          else
          begin
            rf_we = (alu_op != ALU_CP);
            rf_idx = REG_A;
            rf_val = alu_out;
            flag_we = 1'b1;
            flag_val = (alu_out == RESET_BYTE);
          end
        end
      ST_RD_HI:
        if (mem_ack)
        begin
          wide_we = 1'b1;
          wide_sel = WIDE_DE;
          wide_val = {mem_rdata, imm_r};
          st_nxt = ST_OPC;
          insn_done = 1'b1;
        end
      ST_WR:
        if (mem_ack)
        begin
          blk_step = ext_r && !bitop_r;
          st_nxt = ST_OPC;
          insn_done = 1'b1;
        end
      default: st_nxt = ST_OPC;
    endcase
  end

  // sequencer state and instruction latches
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_r <= ST_OPC;
      ptr_r <= RESET_WIDE;
      wdata_r <= RESET_BYTE;
      imm_r <= RESET_BYTE;
      op_r <= RESET_BYTE;
      pfx_r <= IDX_NONE;
      ext_r <= 1'b0;
      bitop_r <= 1'b0;
    end
    else
    begin
      state_r <= st_nxt;
      ptr_r <= ptr_nxt;
      wdata_r <= wdata_nxt;
      imm_r <= imm_nxt;
      if ((opcode_fetch_cycle && take && !is_prefix)
          || (state_r == ST_OP2 && take))
        op_r <= b;
      if (insn_done)
      begin
        pfx_r <= IDX_NONE;
        ext_r <= 1'b0;
        bitop_r <= 1'b0;
      end
      else if (opcode_fetch_cycle && take && is_prefix)
      begin
        if (b == PFX_FIRST)
          pfx_r <= IDX_FIRST;
        if (b == PFX_SECOND)
          pfx_r <= IDX_SECOND;
        ext_r <= (b == PFX_EXT);
        bitop_r <= (b == PFX_BIT);
      end
    end
  end

  // register file, index registers and flag
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 8; i++)
        rf_r[i] <= RESET_BYTE;
      first_index_register_r <= RESET_WIDE;
      second_index_register_r <= RESET_WIDE;
      zero_flag_r <= 1'b0;
    end
    else
    begin
      if (flag_we)
        zero_flag_r <= flag_val;
      if (rf_we)
        rf_r[rf_idx] <= rf_val;
      if (wide_we)
        case (wide_sel)
          IDX_FIRST: first_index_register_r <= wide_val;
          IDX_SECOND: second_index_register_r <= wide_val;
          WIDE_DE: {rf_r[REG_D], rf_r[REG_E]} <= wide_val;
          default: {rf_r[REG_H], rf_r[REG_L]} <= wide_val;
        endcase
      if (blk_step)
      begin
        {rf_r[REG_H], rf_r[REG_L]} <= step_ptr(primary_pointer_pair, op_r[3]);
        if (!op_r[0])
          {rf_r[REG_D], rf_r[REG_E]} <= step_ptr(de_pair, op_r[3]);
        {rf_r[REG_B], rf_r[REG_C]} <= bc_pair - PTR_STEP;
      end
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_idx_dest_disp;
    state_r == ST_DISP && take && !bitop_r && op_r == OP_LD_PTR_IMM;
  endsequence
  sequence s_idx_dest_imm;
    s_idx_dest_disp ##1 (state_r == ST_IMM && take);
  endsequence
  sequence s_pair_low;
    state_r == ST_RD && ext_r && !bitop_r && op_r == OP_PAIR_VIA_PTR && mem_ack;
  endsequence

  a_index_sum:
    assert property (state_r == ST_DISP && take |=> ptr_r ==
      $past(idx_base) + {{8{$past(b[7])}}, $past(b)})
    else $error("indexed pointer not base plus signed displacement");
  a_second_base:
    assert property (state_r == ST_DISP && take && pfx_r == IDX_SECOND
      |=> ptr_r - $past(second_index_register_r) == {{8{$past(b[7])}}, $past(b)})
    else $error("second index prefix did not select second index");
  a_index_kept:
    assert property (state_r inside {ST_DISP, ST_OP2, ST_RD, ST_WR}
      |=> $stable(first_index_register_r) && $stable(second_index_register_r))
    else $error("index register changed while addressing");
  a_field_copy:
    assert property (main_take && b[7:6] == CLS_LOAD && !uses_mem(b)
      && b != OP_HALT |=> rf_r[$past(b[5:3])] == $past(rf_r[b[2:0]]))
    else $error("register copy fields not honoured");
  a_copy_example:
    assert property (main_take && b == OP_COPY_EXAMPLE
      |=> rf_r[REG_C] == $past(rf_r[REG_B]) && state_r == ST_OPC)
    else $error("copy of B into C failed");
  a_ptr_store:
    assert property (main_take && b == OP_STORE_EXAMPLE && pfx_r == IDX_NONE
      |=> mem_cmd.req && mem_cmd.we && mem_cmd.addr == $past(primary_pointer_pair)
      && mem_cmd.wdata == $past(rf_r[REG_D]))
    else $error("store of D through pointer pair wrong");
  a_acc_implied:
    assert property (main_take && b[7:6] == CLS_ALU && b[2:0] != REG_MEM
      && b[5:3] == ALU_OR |=> state_r == ST_OPC
      && rf_r[REG_A] == ($past(rf_r[REG_A]) | $past(rf_r[b[2:0]])))
    else $error("single byte arithmetic missed accumulator");
  a_bit_select:
    assert property (opcode_fetch_cycle && take && bitop_r
      && b[7:6] == CLS_BIT_SET && b[2:0] != REG_MEM
      |=> rf_r[$past(b[2:0])][$past(b[5:3])] == 1'b1)
    else $error("selected bit was not set");
  a_block_step:
    assert property (blk_step && !op_r[3] |=> primary_pointer_pair ==
      $past(primary_pointer_pair) + PTR_STEP && bc_pair == $past(bc_pair) - PTR_STEP)
    else $error("block step did not move pointers");
  a_pair_high:
    assert property (s_pair_low |=> state_r == ST_RD_HI
      && ptr_r == $past(ptr_r) + PTR_STEP
      && primary_pointer_pair == $past(primary_pointer_pair))
    else $error("high byte pointer step wrong");
  a_disp_then_imm:
    assert property (s_idx_dest_imm |=> state_r == ST_WR
      && mem_cmd.wdata == $past(b)
      && ptr_r == $past(idx_base, 2) + {{8{$past(b[7], 2)}}, $past(b, 2)})
    else $error("indexed immediate store misordered");
  a_wide_order:
    assert property (state_r == ST_IMM_HI && take && pfx_r == IDX_NONE
      |=> primary_pointer_pair == {$past(b), $past(imm_r)})
    else $error("extended immediate byte order wrong");
endmodule

// *** bench/opgen_mem_model.sv ***
// byte-wide operand memory standing at the far side of the core
// assumes mem_cmd launched off rising mclk, answers launched off falling
module opgen_mem_model
  import opgen_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // access from the core
  input wire mem_cmd_type mem_cmd,
  input wire logic [3:0] lat,
  // answer
  output logic [7:0] mem_rdata,
  output logic mem_ack
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] mem [0:65535];
  logic [3:0] wait_r;

  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'h00;
    wait_r = 4'h0;
    mem_ack = 1'b0;
    mem_rdata = 8'h00;
  end

  // lat idle cycles before each ack; data line toggles when not valid
  always @(negedge mclk)
  begin
    if (!rst_n || mem_cmd.req !== 1'b1)
    begin
      mem_ack <= 1'b0;
      wait_r <= 4'h0;
      mem_rdata <= ~mem_rdata;
    end
    else if (wait_r >= lat)
    begin
      mem_ack <= 1'b1;
      wait_r <= 4'h0;
      mem_rdata <= mem[mem_cmd.addr];
    end
    else
    begin
      mem_ack <= 1'b0;
      wait_r <= wait_r + 4'h1;
      mem_rdata <= ~mem_rdata;
    end
  end

  // write lands at the edge that completes the access
  always @(posedge mclk)
  begin
    if (rst_n && mem_cmd.req && mem_ack && mem_cmd.we)
      mem[mem_cmd.addr] <= mem_cmd.wdata;
  end
endmodule

// *** bench/operand_address_generation_tb.sv ***
// self-checking bench for operand address generation
// assumes opgen_mem_model as the operand memory, one 25 MHz clock
module operand_address_generation_tb
  import opgen_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [31:0] prog;
    logic [2:0] len;
    logic [1:0] kind;
    logic [15:0] where;
    logic [15:0] exp;
  } row_type;

  localparam logic [1:0] K_REG = 2'h0;
  localparam logic [1:0] K_WIDE = 2'h1;
  localparam logic [1:0] K_MEM = 2'h2;

  localparam row_type rows [0:19] = '{
    '{32'h21341200, 3'h3, K_REG, 16'(REG_H), 16'h0012},
    '{32'hDD210020, 3'h4, K_WIDE, 16'h0000, 16'h2000},
    '{32'hFD210030, 3'h4, K_WIDE, 16'h0001, 16'h3000},
    '{32'hDD3605A5, 3'h4, K_MEM, 16'h2005, 16'h00A5},
    '{32'hDD36FB5A, 3'h4, K_MEM, 16'h1FFB, 16'h005A},
    '{32'hFD36803C, 3'h4, K_MEM, 16'h2F80, 16'h003C},
    '{32'h36770000, 3'h2, K_MEM, 16'h1234, 16'h0077},
    '{32'h46000000, 3'h1, K_REG, 16'(REG_B), 16'h0077},
    '{32'h48000000, 3'h1, K_REG, 16'(REG_C), 16'h0077},
    '{32'hDD4EFB00, 3'h3, K_REG, 16'(REG_C), 16'h005A},
    '{32'hFD568000, 3'h3, K_REG, 16'(REG_D), 16'h003C},
    '{32'h72000000, 3'h1, K_MEM, 16'h1234, 16'h003C},
    '{32'h7E000000, 3'h1, K_REG, 16'(REG_A), 16'h003C},
    '{32'h81000000, 3'h1, K_REG, 16'(REG_A), 16'h0096},
    '{32'hA8000000, 3'h1, K_REG, 16'(REG_A), 16'h00E1},
    '{32'hB7000000, 3'h1, K_REG, 16'(REG_A), 16'h00E1},
    '{32'hDDCB05DE, 3'h4, K_MEM, 16'h2005, 16'h00AD},
    '{32'hCB800000, 3'h2, K_REG, 16'(REG_B), 16'h0076},
    '{32'hCBC30000, 3'h2, K_REG, 16'(REG_E), 16'h0001},
    '{32'h00000000, 3'h1, K_WIDE, 16'h0000, 16'h2000}
  };

  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ibyte_valid = 1'b0;
  logic [7:0] ibyte_data = 8'h00;
  logic [3:0] lat = 4'h0;
  logic ibyte_ready;
  logic opcode_fetch_cycle;
  logic mem_ack;
  logic zero_flag;
  logic [7:0] mem_rdata;
  mem_cmd_type mem_cmd;
  core_view_type core_view;
  int errors = 0;
  int checks = 0;

  always #20 mclk = ~mclk;

  operand_address_generation dut_u (
    .mclk(mclk), .rst_n(rst_n), .ibyte_valid(ibyte_valid),
    .ibyte_data(ibyte_data), .ibyte_ready(ibyte_ready),
    .opcode_fetch_cycle(opcode_fetch_cycle), .mem_cmd(mem_cmd),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .core_view(core_view),
    .zero_flag(zero_flag)
  );

  opgen_mem_model mem_u (
    .mclk(mclk), .rst_n(rst_n), .mem_cmd(mem_cmd), .lat(lat),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack)
  );

  task automatic wrap_up();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [111:0] g, input logic [111:0] e);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("Error at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask

  task automatic chk_mem(input logic [15:0] a, input logic [7:0] e);
    checks++;
    if (mem_u.mem[a] !== e)
    begin
      errors++;
      $display("Error at %0t: memory %0h holds %0h", $time, a, mem_u.mem[a]);
    end
  endtask

  function automatic logic [7:0] reg_val(input logic [2:0] code);
    case (code)
      REG_A: return core_view.a;
      REG_B: return core_view.b;
      REG_C: return core_view.c;
      REG_D: return core_view.d;
      REG_E: return core_view.e;
      REG_H: return core_view.h;
      default: return core_view.l;
    endcase
  endfunction

  // bounded wait for ready, then byte taken at the next rising edge
  task automatic send(input logic [7:0] b);
    int n;
    @(negedge mclk);
    ibyte_valid = 1'b1;
    ibyte_data = b;
    n = 0;
    while (ibyte_ready !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        errors++;
        $display("Error at %0t: byte not taken", $time);
        wrap_up();
      end
      @(negedge mclk);
    end
    @(posedge mclk);
  endtask

  task automatic run(input logic [31:0] p, input int len);
    int n;
    for (int i = 0; i < len; i++)
      send(p[31 - 8 * i -: 8]);
    @(negedge mclk);
    ibyte_valid = 1'b0;
    n = 0;
    while (opcode_fetch_cycle !== 1'b1 || ibyte_ready !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        errors++;
        $display("Error at %0t: instruction hung", $time);
        wrap_up();
      end
      @(negedge mclk);
    end
  endtask

  task automatic do_reset();
    @(negedge mclk);
    rst_n = 1'b0;
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    chk({ibyte_ready, opcode_fetch_cycle, mem_cmd.req, zero_flag}, 4'hC);
    chk(core_view, 112'h0);
  endtask

  initial
  begin
    do_reset();
    foreach (rows[i])
    begin
      run(rows[i].prog, int'(rows[i].len));
      if (rows[i].kind == K_REG)
        chk(reg_val(rows[i].where[2:0]), rows[i].exp);
      else if (rows[i].kind == K_WIDE)
        chk(rows[i].where[0] ? core_view.second_index
          : core_view.first_index, rows[i].exp);
      else
        chk_mem(rows[i].where, rows[i].exp[7:0]);
    end
    chk(core_view.second_index, 16'h3000);
    // slow memory from here on, wide loads and block steps
    lat = 4'h2;
    mem_u.mem[16'h1235] = 8'h9E;
    mem_u.mem[16'hFFFF] = 8'h11;
    mem_u.mem[16'h0000] = 8'hE1;
    run(32'hED340000, 2);
    chk({core_view.d, core_view.e, core_view.h, core_view.l}, 32'h9E3C1234);
    run(32'h21FFFF00, 3);
    run(32'hED340000, 2);
    chk({core_view.d, core_view.e, core_view.h, core_view.l}, 32'hE111FFFF);
    run(32'hEDA00000, 2);
    chk_mem(16'hE111, 8'h11);
    chk({core_view.b, core_view.c, core_view.d, core_view.e,
      core_view.h, core_view.l}, 48'h7659E1120000);
    run(32'hEDA90000, 2);
    chk({zero_flag, core_view.b, core_view.c, core_view.h, core_view.l},
      33'h17658FFFF);
    run(32'hEDA10000, 2);
    chk({zero_flag, core_view.b, core_view.c, core_view.h, core_view.l},
      33'h076570000);
    run(32'hEDA80000, 2);
    chk_mem(16'hE112, 8'hE1);
    chk({core_view.b, core_view.c, core_view.d, core_view.e,
      core_view.h, core_view.l}, 48'h7656E111FFFF);
    run(32'hCB4F0000, 2);
    chk(zero_flag, 1'b1);
    // reset again after the last instruction
    do_reset();
    wrap_up();
  end
endmodule
